// file: bench/pfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_host_model (
  // Clock and frame control
  input wire logic clk_sys,
  input wire logic frame,
  input wire logic [7:0] tx_byte,
  // Host port pins toward the device
  output logic host_clock_pin_i = 1'h0,
  output logic host_data_pin_i = 1'h0,
  output logic shared_io_two_pin_i = 1'h0
);
  logic [2:0] bit_idx = 3'h7;
  // The serial clock stands still between frames, and the released data line
  // keeps changing so that a stale level can never pass for a good one.
  always @(posedge clk_sys) begin
    shared_io_two_pin_i <= frame;
    if (frame) begin
      host_clock_pin_i <= ~host_clock_pin_i;
      if (host_clock_pin_i) begin
        host_data_pin_i <= tx_byte[bit_idx];
        bit_idx <= bit_idx - 3'h1;
      end
    end else begin
      host_clock_pin_i <= 1'h0;
      host_data_pin_i <= ~host_data_pin_i;
    end
  end
endmodule : pfs_host_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); end end
module testbench;
  import pfs_pkg::*;
  localparam int DEB = 4;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic frame = 1'h0;
  logic host_port_select_strap = 1'h0, function_mode_strap = 1'h0, startup_option_strap = 1'h0;
  logic host_clock_pin_i, host_data_pin_i, shared_io_two_pin_i;
  logic shared_io_one_pin_i = 1'h0, dvs_link_clock_pin_i = 1'h0, dvs_link_data_pin_i = 1'h0;
  logic [3:0] en_pins = 4'h0;
  // The active-low power-on input rests high between presses, as a board would pull it up.
  logic sleep_or_power_request_pin = 1'h0, power_on_button_n = 1'h1;
  logic load_switch_enable_pin_a = 1'h1, load_switch_enable_pin_b = 1'h0;
  logic [NUM_LED-1:0] led_or_io_pin_i = 3'h0, led_mode_is_io = 3'h0, led_sink_on = 3'h0;
  logic spi_miso = 1'h0, i2c_sda_low = 1'h0, dvs_sda_low = 1'h0;
  logic [NUM_GPIO-1:0] gpio_out = 5'h0, gpio_oe = 5'h0, gpio_seq_en = 5'h0;
  logic reset_input_option = 1'h0, power_down_req = 1'h0;
  pfs_pad_s host_data_pin, shared_io_one_pin, shared_io_two_pin, dvs_link_data_pin;
  pfs_pad_s [NUM_LED-1:0] led_or_io_pin;
  pfs_host_s host_core;
  pfs_ls_s load_switch_control_reg;
  logic processor_reset_out_n, slow_clock_output, sleep_request, dvs_link_clock, dvs_link_data;
  logic startup_bank_select, primary_mode, host_port_is_i2c, in_sleep;
  logic [NUM_GPIO-1:0] gpio_in;
  logic [NUM_EN-1:0] group_enable, converter_voltage_select;

  always #25 clk_sys = ~clk_sys;

  pfs_host_model i_pfs_host_model (.clk_sys, .frame, .tx_byte(8'ha5), .host_clock_pin_i,
    .host_data_pin_i, .shared_io_two_pin_i);

  pfs_pin_function_select #(.DEBOUNCE_CYC(DEB)) i_pfs_pin_function_select (
    .enable_or_vsel_pin_one(en_pins[0]), .enable_or_vsel_pin_two(en_pins[1]),
    .enable_or_vsel_pin_three(en_pins[2]), .enable_or_vsel_pin_four(en_pins[3]), .*);

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // Straps are only guaranteed to be taken while reset is released.
  task automatic do_reset(input logic hs, input logic fm);
    @(negedge clk_sys);
    rst = 1'h1;
    host_port_select_strap = hs;
    function_mode_strap = fm;
    startup_option_strap = hs;
    repeat (5) @(negedge clk_sys);
    rst = 1'h0;
    repeat (3) @(negedge clk_sys);
  endtask : do_reset

  task automatic power_up();
    int n;
    int rises;
    logic last;
    n = 0;
    rises = 0;
    last = slow_clock_output;
    power_on_button_n = 1'h0;
    repeat (DEB + 4) @(negedge clk_sys);
    power_on_button_n = 1'h1;
    `CHK(processor_reset_out_n, 1'h0)
    while (processor_reset_out_n !== 1'h1 && n < 8000) begin
      @(negedge clk_sys);
      n++;
      if (slow_clock_output === 1'h1 && last === 1'h0) rises++;
      last = slow_clock_output;
    end
    `CHK(n >= 4850 && n <= 5500, 1'h1)
    `CHK(rises >= 8, 1'h1)
    `CHK(load_switch_control_reg, 2'h1)
    load_switch_enable_pin_a = 1'h0;
    load_switch_enable_pin_b = 1'h1;
    repeat (2) @(negedge clk_sys);
    `CHK(load_switch_control_reg, 2'h1)
  endtask : power_up

  task automatic test_spi_alt();
    logic [2:0] prev;
    do_reset(1'h0, 1'h0);
    `CHK(host_port_is_i2c, 1'h0)
    `CHK({primary_mode, startup_bank_select}, 2'h0)
    spi_miso = 1'h1;
    frame = 1'h1;
    repeat (2) @(negedge clk_sys);
    prev = {host_clock_pin_i, host_data_pin_i, shared_io_two_pin_i};
    repeat (20) begin
      @(negedge clk_sys);
      `CHK(host_core[4:2], prev)
      `CHK(shared_io_one_pin, {1'h1, prev[0]})
      prev = {host_clock_pin_i, host_data_pin_i, shared_io_two_pin_i};
    end
    `CHK({host_data_pin.oe, shared_io_two_pin.oe, host_core.i2c_scl}, 3'h0)
    frame = 1'h0;
    host_port_select_strap = 1'h1;
    function_mode_strap = 1'h1;
    en_pins = 4'ha;
    sleep_or_power_request_pin = 1'h1;
    dvs_link_clock_pin_i = 1'h1;
    repeat (2) @(negedge clk_sys);
    `CHK({host_port_is_i2c, primary_mode}, 2'h0)
    `CHK(converter_voltage_select, 4'ha)
    `CHK(group_enable, 4'h3)
    `CHK({sleep_request, dvs_link_clock}, 2'h0)
    {sleep_or_power_request_pin, dvs_link_clock_pin_i, dvs_link_data_pin_i} = 3'h1;
    repeat (2) @(negedge clk_sys);
    `CHK(group_enable, 4'h4)
    power_up();
    sleep_or_power_request_pin = 1'h1;
    repeat (3) @(negedge clk_sys);
    `CHK(in_sleep, 1'h0)
    $display("Test spi and alternate mode done");
  endtask : test_spi_alt

  task automatic test_i2c_primary();
    logic prev_sda;
    sleep_or_power_request_pin = 1'h0;
    do_reset(1'h1, 1'h1);
    `CHK({host_port_is_i2c, primary_mode, startup_bank_select}, 3'h7)
    {gpio_out, gpio_oe, led_mode_is_io, led_sink_on} = {5'h05, 5'h07, 3'h1, 3'h2};
    {shared_io_one_pin_i, led_or_io_pin_i, i2c_sda_low, dvs_sda_low} = {1'h1, 3'h1, 2'h3};
    {en_pins, dvs_link_clock_pin_i, dvs_link_data_pin_i} = {4'h5, 2'h2};
    load_switch_enable_pin_a = 1'h1;
    load_switch_enable_pin_b = 1'h0;
    repeat (2) @(negedge clk_sys);
    `CHK({shared_io_one_pin, shared_io_two_pin}, 4'hd)
    `CHK(led_or_io_pin, 6'h07)
    `CHK(gpio_in, 5'h05)
    `CHK({host_data_pin, host_core[4:2]}, 5'h08)
    `CHK({group_enable, converter_voltage_select}, 8'h50)
    `CHK({dvs_link_clock, dvs_link_data, dvs_link_data_pin}, 4'h9)
    prev_sda = host_data_pin_i;
    @(negedge clk_sys);
    `CHK({host_core.i2c_scl, host_core.i2c_sda}, {1'h0, prev_sda})
    {gpio_seq_en, gpio_oe, led_mode_is_io} = {5'h10, 5'h0, 3'h4};
    power_up();
    `CHK(led_or_io_pin[2], 2'h3)
    sleep_or_power_request_pin = 1'h1;
    repeat (2) @(negedge clk_sys);
    `CHK({in_sleep, sleep_request}, 2'h3)
    sleep_or_power_request_pin = 1'h0;
    repeat (2) @(negedge clk_sys);
    `CHK(in_sleep, 1'h0)
    power_down_req = 1'h1;
    repeat (2) @(negedge clk_sys);
    `CHK(processor_reset_out_n, 1'h0)
    $display("Test i2c and primary mode done");
  endtask : test_i2c_primary

  // With the reset option the released pin starts power-up at once, and a low level
  // must stand for the whole debounce window before the device powers down.
  task automatic test_reset_option();
    int n;
    n = 0;
    power_down_req = 1'h0;
    reset_input_option = 1'h1;
    do_reset(1'h1, 1'h1);
    while (processor_reset_out_n !== 1'h1 && n < 8000) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n >= 4870 && n <= 5500, 1'h1)
    power_on_button_n = 1'h0;
    repeat (DEB - 2) @(negedge clk_sys);
    power_on_button_n = 1'h1;
    repeat (DEB + 2) @(negedge clk_sys);
    `CHK(processor_reset_out_n, 1'h1)
    power_on_button_n = 1'h0;
    repeat (DEB) @(negedge clk_sys);
    `CHK(processor_reset_out_n, 1'h1)
    repeat (3) @(negedge clk_sys);
    `CHK(processor_reset_out_n, 1'h0)
    $display("Test reset option done");
  endtask : test_reset_option

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    test_spi_alt();
    test_i2c_primary();
    test_reset_option();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// file: common/pfs_pkg.sv
`default_nettype none
package pfs_pkg;
  // System clock and the slow sequencing clock derived from it.
  localparam int CLK_HZ = 20_000_000;
  localparam int SLOW_HZ = 32_768;
  localparam int SLOW_DIV_W = 9;
  localparam logic [SLOW_DIV_W-1:0] SLOW_HALF_CYC = SLOW_DIV_W'(CLK_HZ / (2 * SLOW_HZ));

  // Power-on and reset-input debounce, in milliseconds and in clock cycles.
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYC = ((CLK_HZ / 1000) * DEBOUNCE_MS);
  localparam int DEB_W = 18;

  // Sequencer lengths, counted in slow-clock ticks.
  localparam int SEQ_W = 4;
  localparam logic [SEQ_W-1:0] SEQ_TICKS = 4'h8;
  localparam logic [SEQ_W-1:0] DOWN_TICKS = 4'h8;
  localparam logic [SEQ_W-1:0] SEQ_GPIO_STEP = 4'h4;

  // Pin counts and indices.
  localparam int NUM_GPIO = 5;
  localparam int NUM_LED = 3;
  localparam int NUM_EN = 4;
  localparam int GPIO_ONE = 0;
  localparam int GPIO_TWO = 1;
  localparam int GPIO_LED_BASE = 2;
  localparam int GRP_ONE = 0;
  localparam int GRP_TWO = 1;
  localparam int GRP_THREE = 2;
  localparam int GRP_FOUR = 3;

  // Strap levels: ground selects SPI, the always-on supply selects primary functions.
  localparam logic STRAP_I2C = 1'h1;
  localparam logic STRAP_PRIMARY = 1'h1;

  typedef enum logic [2:0] {
    PFS_OFF = 3'h0,
    PFS_CONFIG = 3'h1,
    PFS_SEQ = 3'h3,
    PFS_ACTIVE = 3'h2,
    PFS_SLEEP = 3'h6,
    PFS_DOWN = 3'h4
  } pfs_state_e;

  typedef struct packed {
    logic o;
    logic oe;
  } pfs_pad_s;

  typedef struct packed {
    logic spi_sck;
    logic spi_mosi;
    logic spi_cs;
    logic i2c_scl;
    logic i2c_sda;
  } pfs_host_s;

  typedef struct packed {
    logic load_switch_bit_b;
    logic load_switch_bit_a;
  } pfs_ls_s;
endpackage : pfs_pkg
`default_nettype wire

// file: rtl/pfs_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_debounce #(
  parameter int unsigned CYC = pfs_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Raw level and accepted level
  input wire logic raw,
  output logic level,
  output logic fell
);
  import pfs_pkg::*;

  typedef struct packed {
    logic level;
    logic fell;
    logic [DEB_W-1:0] cnt;
  } pfs_deb_s;

  localparam logic [DEB_W-1:0] LIMIT = DEB_W'(CYC - 1);

  pfs_deb_s d;
  pfs_deb_s next_d;

  // A new level is accepted only after it has stood unbroken for the whole window.
  always_comb begin
    next_d = d;
    next_d.fell = 1'h0;
    if (raw == d.level) begin
      next_d.cnt = '0;
    end else if (d.cnt == LIMIT) begin
      next_d.level = raw;
      next_d.fell = ~raw;
      next_d.cnt = '0;
    end else begin
      next_d.cnt = d.cnt + DEB_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      d <= '{level: 1'h1, fell: 1'h0, cnt: '0};
    end else begin
      d <= next_d;
    end
  end

  assign level = d.level;
  assign fell = d.fell;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_DEB_WINDOW: assert property ($changed(level) |-> $past(d.cnt) == LIMIT && $past(raw) == level)
    else $error("accepted level changed before the debounce window ran out");
endmodule : pfs_debounce
`default_nettype wire

// file: rtl/pfs_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_function_select #(
  parameter int unsigned DEBOUNCE_CYC = pfs_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Straps
  input wire logic host_port_select_strap,
  input wire logic function_mode_strap,
  input wire logic startup_option_strap,
  // Host port pins
  input wire logic host_clock_pin_i,
  input wire logic host_data_pin_i,
  output pfs_pkg::pfs_pad_s host_data_pin,
  input wire logic shared_io_one_pin_i,
  output pfs_pkg::pfs_pad_s shared_io_one_pin,
  input wire logic shared_io_two_pin_i,
  output pfs_pkg::pfs_pad_s shared_io_two_pin,
  // Enable or voltage-select pins
  input wire logic enable_or_vsel_pin_one,
  input wire logic enable_or_vsel_pin_two,
  input wire logic enable_or_vsel_pin_three,
  input wire logic enable_or_vsel_pin_four,
  // Power I2C or clock-request pins, and the sleep pin
  input wire logic dvs_link_clock_pin_i,
  input wire logic dvs_link_data_pin_i,
  output pfs_pkg::pfs_pad_s dvs_link_data_pin,
  input wire logic sleep_or_power_request_pin,
  // Power-on, load switch, LED pins
  input wire logic power_on_button_n,
  input wire logic load_switch_enable_pin_a,
  input wire logic load_switch_enable_pin_b,
  input wire logic [pfs_pkg::NUM_LED-1:0] led_or_io_pin_i,
  output pfs_pkg::pfs_pad_s [pfs_pkg::NUM_LED-1:0] led_or_io_pin,
  // System outputs
  output logic processor_reset_out_n,
  output logic slow_clock_output,
  // Host port toward the core
  output pfs_pkg::pfs_host_s host_core,
  input wire logic spi_miso,
  input wire logic i2c_sda_low,
  // GPIO toward the core
  output logic [pfs_pkg::NUM_GPIO-1:0] gpio_in,
  input wire logic [pfs_pkg::NUM_GPIO-1:0] gpio_out,
  input wire logic [pfs_pkg::NUM_GPIO-1:0] gpio_oe,
  input wire logic [pfs_pkg::NUM_GPIO-1:0] gpio_seq_en,
  input wire logic [pfs_pkg::NUM_LED-1:0] led_mode_is_io,
  input wire logic [pfs_pkg::NUM_LED-1:0] led_sink_on,
  // Resource control toward the core
  output logic [pfs_pkg::NUM_EN-1:0] group_enable,
  output logic [pfs_pkg::NUM_EN-1:0] converter_voltage_select,
  output logic sleep_request,
  output logic dvs_link_clock,
  output logic dvs_link_data,
  input wire logic dvs_sda_low,
  output pfs_pkg::pfs_ls_s load_switch_control_reg,
  // Options and status
  input wire logic reset_input_option,
  input wire logic power_down_req,
  output logic startup_bank_select,
  output logic primary_mode,
  output logic host_port_is_i2c,
  output logic in_sleep
);
  import pfs_pkg::*;

  typedef struct packed {
    pfs_state_e st;
    logic strap_valid;
    logic host_i2c;
    logic func_primary;
    logic startup_bank;
    logic [SLOW_DIV_W-1:0] div_cnt;
    logic slow_clk;
    logic [SEQ_W-1:0] seq_cnt;
    logic rst_out_n;
    pfs_ls_s ls;
    pfs_host_s host;
    pfs_pad_s data_pad;
    pfs_pad_s one_pad;
    pfs_pad_s two_pad;
    pfs_pad_s dvs_pad;
    pfs_pad_s [NUM_LED-1:0] led_pad;
    logic [NUM_GPIO-1:0] gin;
    logic [NUM_EN-1:0] grp;
    logic [NUM_EN-1:0] vsel;
    logic sleep_req;
    logic dvs_clk;
    logic dvs_dat;
  } pfs_q_s;

  pfs_q_s q;
  pfs_q_s next_q;
  logic deb_level;
  logic deb_fell;
  logic slow_tick;
  logic start_up;
  logic go_down;
  logic seq_gpio_on;
  logic [NUM_GPIO-1:0] gpio_drv;
  logic [NUM_GPIO-1:0] gpio_en;
  logic [NUM_EN-1:0] en_pins;

  // The same debouncer serves both meanings of the power-on pin.
  pfs_debounce #(
    .CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw(power_on_button_n),
    .level(deb_level),
    .fell(deb_fell)
  );

  assign en_pins = {enable_or_vsel_pin_four, enable_or_vsel_pin_three,
                    enable_or_vsel_pin_two, enable_or_vsel_pin_one};

  // One slow tick per rising edge of the slow clock.
  assign slow_tick = (q.div_cnt == SLOW_HALF_CYC - SLOW_DIV_W'(1)) && !q.slow_clk;

  // In reset-input mode the pin holds the device down while low, so release starts it.
  assign start_up = reset_input_option ? deb_level : deb_fell;
  assign go_down = power_down_req || (reset_input_option && !deb_level);

  assign seq_gpio_on = (q.st == PFS_SEQ && q.seq_cnt >= SEQ_GPIO_STEP) ||
                       q.st == PFS_ACTIVE || q.st == PFS_SLEEP;

  // A GPIO that is a sequence step ignores the core and follows the sequencer.
  always_comb begin
    for (int i = 0; i < NUM_GPIO; i++) begin
      gpio_drv[i] = gpio_seq_en[i] ? seq_gpio_on : gpio_out[i];
      gpio_en[i] = gpio_seq_en[i] | gpio_oe[i];
    end
  end

  always_comb begin
    next_q = q;

    // Straps are caught in the first cycle after release and never again.
    if (!q.strap_valid) begin
      next_q.strap_valid = 1'h1;
      next_q.host_i2c = (host_port_select_strap == STRAP_I2C);
      next_q.func_primary = (function_mode_strap == STRAP_PRIMARY);
      next_q.startup_bank = startup_option_strap;
    end

    // The slow clock runs from reset onward, whatever the sequencer does.
    if (q.div_cnt == SLOW_HALF_CYC - SLOW_DIV_W'(1)) begin
      next_q.div_cnt = '0;
      next_q.slow_clk = ~q.slow_clk;
    end else begin
      next_q.div_cnt = q.div_cnt + SLOW_DIV_W'(1);
    end

    case (q.st)
      PFS_OFF: begin
        if (q.strap_valid && start_up) begin
          next_q.st = PFS_CONFIG;
        end
      end
      PFS_CONFIG: begin
        next_q.ls.load_switch_bit_a = load_switch_enable_pin_a;
        next_q.ls.load_switch_bit_b = load_switch_enable_pin_b;
        if (slow_tick) begin
          next_q.st = PFS_SEQ;
          next_q.seq_cnt = '0;
        end
      end
      PFS_SEQ: begin
        if (go_down) begin
          next_q.st = PFS_DOWN;
          next_q.seq_cnt = '0;
        end else if (slow_tick) begin
          if (q.seq_cnt == SEQ_TICKS - SEQ_W'(1)) begin
            next_q.st = PFS_ACTIVE;
          end else begin
            next_q.seq_cnt = q.seq_cnt + SEQ_W'(1);
          end
        end
      end
      PFS_ACTIVE: begin
        if (go_down) begin
          next_q.st = PFS_DOWN;
          next_q.seq_cnt = '0;
        end else if (q.func_primary && sleep_or_power_request_pin) begin
          next_q.st = PFS_SLEEP;
        end
      end
      PFS_SLEEP: begin
        if (go_down) begin
          next_q.st = PFS_DOWN;
          next_q.seq_cnt = '0;
        end else if (!q.func_primary || !sleep_or_power_request_pin) begin
          next_q.st = PFS_ACTIVE;
        end
      end
      PFS_DOWN: begin
        if (slow_tick) begin
          if (q.seq_cnt == DOWN_TICKS - SEQ_W'(1)) begin
            next_q.st = PFS_OFF;
          end else begin
            next_q.seq_cnt = q.seq_cnt + SEQ_W'(1);
          end
        end
      end
      default: begin
        next_q.st = PFS_OFF;
      end
    endcase

    // The processor sees reset released only once sequencing has finished.
    next_q.rst_out_n = (next_q.st == PFS_ACTIVE) || (next_q.st == PFS_SLEEP);

    // Host port pins.
    next_q.host = '0;
    next_q.gin = '0;
    if (q.host_i2c) begin
      next_q.host.i2c_scl = host_clock_pin_i;
      next_q.host.i2c_sda = host_data_pin_i;
      next_q.data_pad = '{o: 1'h0, oe: i2c_sda_low};
      next_q.one_pad = '{o: gpio_drv[GPIO_ONE], oe: gpio_en[GPIO_ONE]};
      next_q.two_pad = '{o: gpio_drv[GPIO_TWO], oe: gpio_en[GPIO_TWO]};
      next_q.gin[GPIO_ONE] = shared_io_one_pin_i;
      next_q.gin[GPIO_TWO] = shared_io_two_pin_i;
    end else begin
      next_q.host.spi_sck = host_clock_pin_i;
      next_q.host.spi_mosi = host_data_pin_i;
      next_q.host.spi_cs = shared_io_two_pin_i;
      next_q.data_pad = '{o: 1'h0, oe: 1'h0};
      // Driving only while selected lets several devices share the return line.
      next_q.one_pad = '{o: spi_miso, oe: shared_io_two_pin_i};
      next_q.two_pad = '{o: 1'h0, oe: 1'h0};
    end

    // LED pins, each an open sink or a GPIO.
    for (int i = 0; i < NUM_LED; i++) begin
      if (led_mode_is_io[i]) begin
        next_q.led_pad[i] = '{o: gpio_drv[GPIO_LED_BASE + i], oe: gpio_en[GPIO_LED_BASE + i]};
        next_q.gin[GPIO_LED_BASE + i] = led_or_io_pin_i[i];
      end else begin
        next_q.led_pad[i] = '{o: 1'h0, oe: led_sink_on[i]};
      end
    end

    // Enable, voltage-select, power I2C and request pins.
    next_q.grp = '0;
    next_q.vsel = '0;
    next_q.sleep_req = 1'h0;
    next_q.dvs_clk = 1'h0;
    next_q.dvs_dat = 1'h0;
    next_q.dvs_pad = '{o: 1'h0, oe: 1'h0};
    if (q.func_primary) begin
      next_q.grp = en_pins;
      next_q.sleep_req = sleep_or_power_request_pin;
      next_q.dvs_clk = dvs_link_clock_pin_i;
      next_q.dvs_dat = dvs_link_data_pin_i;
      next_q.dvs_pad = '{o: 1'h0, oe: dvs_sda_low};
    end else begin
      next_q.vsel = en_pins;
      next_q.grp[GRP_ONE] = sleep_or_power_request_pin;
      next_q.grp[GRP_TWO] = dvs_link_clock_pin_i;
      next_q.grp[GRP_THREE] = dvs_link_data_pin_i;
      next_q.grp[GRP_FOUR] = 1'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign processor_reset_out_n = q.rst_out_n;
  assign slow_clock_output = q.slow_clk;
  assign host_data_pin = q.data_pad;
  assign shared_io_one_pin = q.one_pad;
  assign shared_io_two_pin = q.two_pad;
  assign dvs_link_data_pin = q.dvs_pad;
  assign led_or_io_pin = q.led_pad;
  assign host_core = q.host;
  assign gpio_in = q.gin;
  assign group_enable = q.grp;
  assign converter_voltage_select = q.vsel;
  assign sleep_request = q.sleep_req;
  assign dvs_link_clock = q.dvs_clk;
  assign dvs_link_data = q.dvs_dat;
  assign load_switch_control_reg = q.ls;
  assign startup_bank_select = q.startup_bank;
  assign primary_mode = q.func_primary;
  assign host_port_is_i2c = q.host_i2c;
  assign in_sleep = (q.st == PFS_SLEEP);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_SPI_SELECT: assert property (q.strap_valid && !q.host_i2c |=> host_core.spi_cs == $past(shared_io_two_pin_i)
    && !shared_io_two_pin.oe && host_core.spi_sck == $past(host_clock_pin_i))
    else $error("SPI selection does not route chip select and clock");
  AST_I2C_GPIO: assert property (q.strap_valid && q.host_i2c |=> gpio_in[GPIO_TWO] == $past(shared_io_two_pin_i)
    && host_core.i2c_sda == $past(host_data_pin_i) && !host_core.spi_cs)
    else $error("I2C selection does not route SDA and GPIO two");
  AST_MISO_DRIVE: assert property (q.strap_valid && !q.host_i2c && shared_io_two_pin_i
    |=> shared_io_one_pin.oe && shared_io_one_pin.o == $past(spi_miso))
    else $error("SPI data toward host not driven while selected");
  AST_PRIMARY_EN: assert property (q.strap_valid && q.func_primary |=> group_enable == $past(en_pins)
    && converter_voltage_select == '0 && dvs_link_clock == $past(dvs_link_clock_pin_i))
    else $error("primary mode enable pins not mapped to groups");
  AST_ALT_MAP: assert property (q.strap_valid && !q.func_primary |=> converter_voltage_select == $past(en_pins)
    && group_enable[GRP_TWO] == $past(dvs_link_clock_pin_i) && group_enable[GRP_THREE] == $past(dvs_link_data_pin_i))
    else $error("alternate mode select or clock requests not mapped");
  AST_POWER_REQUEST_INPUT: assert property (q.strap_valid && !q.func_primary |=> group_enable[GRP_ONE] == $past(sleep_or_power_request_pin)
    && !sleep_request)
    else $error("power request does not drive group one");
  AST_NO_SLEEP_ALT: assert property (q.strap_valid && !q.func_primary |=> q.st != PFS_SLEEP)
    else $error("sleep entered in alternate mode");
  AST_RESET_HELD: assert property (q.st != PFS_ACTIVE && q.st != PFS_SLEEP |-> !processor_reset_out_n)
    else $error("processor reset released before sequence end");
  AST_RESET_AFTER_SEQ: assert property ($rose(processor_reset_out_n) |-> $past(q.st) == PFS_SEQ
    && $past(q.seq_cnt) == SEQ_TICKS - SEQ_W'(1))
    else $error("processor reset released without the full sequence");
  AST_LS_COPY: assert property (q.st == PFS_CONFIG |=> load_switch_control_reg ==
    $past({load_switch_enable_pin_b, load_switch_enable_pin_a}))
    else $error("load-switch bits not copied in configuration state");
  AST_BUTTON_START: assert property (q.st == PFS_OFF && q.strap_valid && !reset_input_option && deb_fell
    |=> q.st == PFS_CONFIG)
    else $error("accepted power-on press did not start power-up");
  AST_STRAP_STATIC: assert property (q.strap_valid |=> $stable(q.host_i2c) && $stable(q.func_primary)
    && $stable(startup_bank_select))
    else $error("strap selection changed after capture");
  AST_SLOW_CLK: assert property ($changed(slow_clock_output) |-> $past(q.div_cnt) == SLOW_HALF_CYC - SLOW_DIV_W'(1))
    else $error("slow clock half period wrong");

  COV_ACTIVE: cover property (q.st == PFS_SEQ ##1 q.st == PFS_ACTIVE);
  COV_SLEEP: cover property (q.st == PFS_ACTIVE ##1 q.st == PFS_SLEEP);
  COV_DOWN: cover property (q.st == PFS_DOWN ##1 q.st == PFS_OFF);
  COV_ALT_ACTIVE: cover property (!q.func_primary && q.st == PFS_ACTIVE && converter_voltage_select != '0);
endmodule : pfs_pin_function_select
`default_nettype wire
